// >>> rtl/counter_array_pkg.sv
/*
  constants for the counter array: clock source codes, module modes, pwm widths, watchdog setup.
  assumes a single system clock domain; no bus, all control bits are plain ports.
*/
package counter_array_pkg;
  localparam int NUM_MODULES = 6;
  localparam int CNT_W = 16;
  localparam int WDOG_IDX = 5;
  // counter clock source select codes
  localparam logic [2:0] SRC_DIV12 = 3'h0;
  localparam logic [2:0] SRC_DIV4 = 3'h1;
  localparam logic [2:0] SRC_T0_OVF = 3'h2;
  localparam logic [2:0] SRC_EXT_CNT = 3'h3;
  localparam logic [2:0] SRC_SYSCLK = 3'h4;
  localparam logic [2:0] SRC_XOSC_DIV8 = 3'h5;
  localparam logic [3:0] DIV12_LAST = 4'hB;
  localparam logic [1:0] DIV4_LAST = 2'h3;
  localparam logic [2:0] DIV8_LAST = 3'h7;
  // module mode codes
  localparam logic [2:0] MODE_OFF = 3'h0;
  localparam logic [2:0] MODE_CAPTURE = 3'h1;
  localparam logic [2:0] MODE_SW_TIMER = 3'h2;
  localparam logic [2:0] MODE_HS_OUT = 3'h3;
  localparam logic [2:0] MODE_FREQ_OUT = 3'h4;
  localparam logic [2:0] MODE_PWM = 3'h5;
  // capture edge select bits
  localparam int EDGE_RISE_BIT = 0;
  localparam int EDGE_FALL_BIT = 1;
  // pwm width codes: 8, 9, 10, 11, 16 bits
  localparam logic [2:0] PWM_W8 = 3'h0;
  localparam logic [2:0] PWM_W9 = 3'h1;
  localparam logic [2:0] PWM_W10 = 3'h2;
  localparam logic [2:0] PWM_W11 = 3'h3;
  localparam logic [2:0] PWM_W16 = 3'h4;
  // reset values
  localparam logic [15:0] CNT_RESET = 16'h0000;
  localparam logic WDOG_EN_RESET = 1'b1;
  localparam logic [7:0] WDOG_LIMIT_RESET = 8'hFF;
endpackage

// >>> rtl/counter_array_module.sv
/*
  one capture/compare module of the counter array.
  assumes the shared counter and its advance pulse come from the parent on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none
module counter_array_module (
  // clock and reset
  input wire logic clk_sys_in,
  input wire logic rst_in,
  // shared time base
  input wire logic [15:0] count_in,
  input wire logic tick_in,
  // configuration
  input wire logic [2:0] mode_in,
  input wire logic [1:0] edge_sel_in,
  input wire logic [2:0] pwm_width_in,
  input wire logic [15:0] compare_in,
  input wire logic pin_in,
  // results
  output logic [15:0] capture_out,
  output logic match_out,
  output logic pin_out
);
  logic pin_d_r;
  logic [15:0] capture_r;
  logic out_r;
  logic [15:0] pwm_mask;
  logic rise;
  logic fall;
  logic cap_hit;
  logic cmp_hit;
  logic pwm_wrap;
  logic [15:0] freq_cnt_r;
  logic freq_hit;

  // edge detection on module input
  assign rise = pin_in & ~pin_d_r;
  assign fall = ~pin_in & pin_d_r;
  assign cap_hit = (mode_in == counter_array_pkg::MODE_CAPTURE) &&
    ((rise && edge_sel_in[counter_array_pkg::EDGE_RISE_BIT]) ||
     (fall && edge_sel_in[counter_array_pkg::EDGE_FALL_BIT]));
  // pwm width mask
  assign pwm_mask = (pwm_width_in == counter_array_pkg::PWM_W8) ? 16'h00FF :
    (pwm_width_in == counter_array_pkg::PWM_W9) ? 16'h01FF :
    (pwm_width_in == counter_array_pkg::PWM_W10) ? 16'h03FF :
    (pwm_width_in == counter_array_pkg::PWM_W11) ? 16'h07FF : 16'hFFFF;
  assign pwm_wrap = tick_in && ((count_in & pwm_mask) == pwm_mask);
  assign freq_hit = tick_in && (freq_cnt_r == compare_in);
  assign cmp_hit = tick_in && (count_in == compare_in) &&
    ((mode_in == counter_array_pkg::MODE_SW_TIMER) ||
     (mode_in == counter_array_pkg::MODE_HS_OUT));
  assign match_out = cap_hit | cmp_hit |
    ((mode_in == counter_array_pkg::MODE_PWM) && pwm_wrap) |
    ((mode_in == counter_array_pkg::MODE_FREQ_OUT) && freq_hit);
  assign capture_out = capture_r;
  assign pin_out = out_r;

  // mode state and output pin
  always_ff @(posedge clk_sys_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      pin_d_r <= 1'b0;
      capture_r <= 16'h0000;
      out_r <= 1'b0;
      freq_cnt_r <= 16'h0000;
    end
    else
    begin
      pin_d_r <= pin_in;
      if (cap_hit)
        capture_r <= count_in;
      if (mode_in == counter_array_pkg::MODE_HS_OUT && cmp_hit)
        out_r <= ~out_r;
      else if (mode_in == counter_array_pkg::MODE_PWM && tick_in)
        out_r <= (count_in & pwm_mask) >= (compare_in & pwm_mask);
      else if (mode_in == counter_array_pkg::MODE_FREQ_OUT && freq_hit)
        out_r <= ~out_r;
      if (mode_in != counter_array_pkg::MODE_FREQ_OUT || freq_hit)
        freq_cnt_r <= 16'h0000;
      else if (tick_in)
        freq_cnt_r <= freq_cnt_r + 16'h0001;
    end
  end

  // flag fires only in the cycle of a capture edge, a compare match, a pwm width wrap or a frequency-output toggle
  AST_CAPTURE_LOADS: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    cap_hit |=> capture_r == $past(count_in))
    else $error("capture register did not load counter");
  AST_HSO_TOGGLES: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    (mode_in == counter_array_pkg::MODE_HS_OUT && cmp_hit) |=> out_r != $past(out_r))
    else $error("high speed output did not toggle on match");
  AST_PWM_LEVEL: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    (mode_in == counter_array_pkg::MODE_PWM && tick_in && !cmp_hit &&
     (count_in & pwm_mask) < (compare_in & pwm_mask)) |=> !out_r)
    else $error("pwm output high below compare level");
  COV_CAPTURE: cover property (@(posedge clk_sys_in) disable iff (rst_in) cap_hit);
endmodule // counter_array_module
`default_nettype wire

// >>> rtl/counter_array.sv
/*
  counter array top: shared 16-bit time base, clock source select, six capture/compare
  modules and a watchdog on the shared counter high byte, apart from the modules, with its reset request.
  assumes all inputs synchronous to clk_sys_in except the external count input and xosc_in, which are
  synchronised here; crossbar routing is outside, modules expose plain pin signals.
*/
`timescale 1ns/1ps
`default_nettype none
module counter_array (
  // clock and reset
  input wire logic clk_sys_in,
  input wire logic rst_in,
  input wire logic por_in,
  // time base control
  input wire logic run_in,
  input wire logic [2:0] clk_src_in,
  input wire logic timer0_ovf_in,
  input wire logic xosc_in,
  input wire logic external_count_input_in,
  // per-module configuration, flattened by module index, then the shared overflow flag controls
  input wire logic [17:0] mode_in,
  input wire logic [11:0] edge_sel_in,
  input wire logic [17:0] pwm_width_in,
  input wire logic [95:0] compare_in,
  input wire logic [5:0] mod_pin_in,
  input wire logic [5:0] flag_clr_in,
  input wire logic [5:0] flag_ie_in,
  input wire logic ovf_clr_in,
  input wire logic ovf_ie_in,
  // watchdog control and flash error reset source
  input wire logic wdog_disable_in,
  input wire logic wdog_kick_in,
  input wire logic [7:0] wdog_limit_in,
  input wire logic wdog_limit_we_in,
  input wire logic wdog_rst_mask_in,
  input wire logic flash_err_in,
  // status and pins
  output logic [15:0] count_out,
  output logic [95:0] capture_out,
  output logic [5:0] mod_pin_out,
  output logic [5:0] flag_out,
  output logic ovf_flag_out,
  output logic irq_out,
  output logic wdog_en_out,
  output logic wdog_rst_out,
  output logic sys_rst_req_out
);
  logic [15:0] count_r;
  logic [3:0] div12_r;
  logic [1:0] div4_r;
  logic [2:0] div8_r;
  logic xosc_s1_r;
  logic xosc_s2_r;
  logic xosc_d_r;
  logic eci_s1_r;
  logic eci_s2_r;
  logic eci_d_r;
  logic [5:0] flag_r;
  logic ovf_r;
  logic wdog_en_r;
  logic wdog_locked_r;
  logic [7:0] wdog_limit_r;
  logic [7:0] wdog_base_r;
  logic wdog_rst_r;
  logic tick;
  logic eci_rise;
  logic xosc_rise;
  logic [5:0] match;
  logic [7:0] wdog_target;
  logic wdog_expire;

  // source edge detectors, first sync stage only feeds the second
  assign eci_rise = eci_s2_r & ~eci_d_r;
  assign xosc_rise = xosc_s2_r & ~xosc_d_r;
  // counter advance select
  assign tick = run_in && (
    (clk_src_in == counter_array_pkg::SRC_DIV12 && div12_r == counter_array_pkg::DIV12_LAST) ||
    (clk_src_in == counter_array_pkg::SRC_DIV4 && div4_r == counter_array_pkg::DIV4_LAST) ||
    (clk_src_in == counter_array_pkg::SRC_T0_OVF && timer0_ovf_in) ||
    (clk_src_in == counter_array_pkg::SRC_EXT_CNT && eci_rise) ||
    (clk_src_in == counter_array_pkg::SRC_SYSCLK) ||
    (clk_src_in == counter_array_pkg::SRC_XOSC_DIV8 && xosc_rise &&
     div8_r == counter_array_pkg::DIV8_LAST));
  // watchdog expires when the counter low byte wraps while the high byte equals base plus limit
  assign wdog_target = wdog_base_r + wdog_limit_r;
  assign wdog_expire = wdog_en_r && !wdog_locked_r && tick && (count_r[15:8] == wdog_target) &&
    (count_r[7:0] == 8'hFF);
  assign count_out = count_r;
  assign flag_out = flag_r;
  assign ovf_flag_out = ovf_r;
  assign irq_out = |(flag_r & flag_ie_in) | (ovf_r & ovf_ie_in);
  // the lock hides the reset-time enable, so a locked watchdog never shows on
  assign wdog_en_out = wdog_en_r & ~wdog_locked_r;
  assign wdog_rst_out = wdog_rst_r;
  assign sys_rst_req_out = por_in | flash_err_in | wdog_rst_r;

  // synchronisers and prescalers
  always_ff @(posedge clk_sys_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      eci_s1_r <= 1'b0;
      eci_s2_r <= 1'b0;
      eci_d_r <= 1'b0;
      xosc_s1_r <= 1'b0;
      xosc_s2_r <= 1'b0;
      xosc_d_r <= 1'b0;
      div12_r <= 4'h0;
      div4_r <= 2'h0;
      div8_r <= 3'h0;
    end
    else
    begin
      eci_s1_r <= external_count_input_in;
      eci_s2_r <= eci_s1_r;
      eci_d_r <= eci_s2_r;
      xosc_s1_r <= xosc_in;
      xosc_s2_r <= xosc_s1_r;
      xosc_d_r <= xosc_s2_r;
      div12_r <= (div12_r == counter_array_pkg::DIV12_LAST) ? 4'h0 : div12_r + 4'h1;
      div4_r <= div4_r + 2'h1;
      if (xosc_rise)
        div8_r <= div8_r + 3'h1;
    end
  end

  // shared time base and flags; a set wins over a clear in the same cycle
  always_ff @(posedge clk_sys_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      count_r <= counter_array_pkg::CNT_RESET;
      ovf_r <= 1'b0;
      flag_r <= 6'h00;
    end
    else
    begin
      if (tick)
        count_r <= count_r + 16'h0001;
      ovf_r <= (tick && count_r == 16'hFFFF) | (ovf_r & ~ovf_clr_in);
      flag_r <= match | (flag_r & ~flag_clr_in);
    end
  end

  // watchdog: enabled on every reset, disable lock clears only on power-on
  always_ff @(posedge clk_sys_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      wdog_en_r <= counter_array_pkg::WDOG_EN_RESET;
      wdog_limit_r <= counter_array_pkg::WDOG_LIMIT_RESET;
      wdog_base_r <= 8'h00;
      wdog_rst_r <= 1'b0;
    end
    else
    begin
      if (wdog_disable_in || wdog_locked_r)
        wdog_en_r <= 1'b0;
      if (wdog_limit_we_in)
        wdog_limit_r <= wdog_limit_in;
      if (wdog_kick_in)
        wdog_base_r <= count_r[15:8];
      wdog_rst_r <= wdog_expire & ~wdog_rst_mask_in;
    end
  end

  // disable lock survives system reset, cleared only by power-on
  always_ff @(posedge clk_sys_in or posedge por_in)
  begin
    if (por_in)
      wdog_locked_r <= 1'b0;
    else if (wdog_disable_in)
      wdog_locked_r <= 1'b1;
  end

  // six modules on the shared counter; pins leave toward the crossbar
  genvar gi;
  generate
    for (gi = 0; gi < counter_array_pkg::NUM_MODULES; gi++)
    begin : g_mod
      counter_array_module u_mod (
        .clk_sys_in(clk_sys_in),
        .rst_in(rst_in),
        .count_in(count_r),
        .tick_in(tick),
        .mode_in(mode_in[3*gi +: 3]),
        .edge_sel_in(edge_sel_in[2*gi +: 2]),
        .pwm_width_in(pwm_width_in[3*gi +: 3]),
        .compare_in(compare_in[16*gi +: 16]),
        .pin_in(mod_pin_in[gi]),
        .capture_out(capture_out[16*gi +: 16]),
        .match_out(match[gi]),
        .pin_out(mod_pin_out[gi])
      );
    end
  endgenerate

  AST_COUNT_ADVANCES: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    tick |=> count_r == $past(count_r) + 16'h0001)
    else $error("counter did not advance on tick");
  AST_SYSCLK_TICK: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    (run_in && clk_src_in == counter_array_pkg::SRC_SYSCLK) |-> tick)
    else $error("sysclk source did not tick");
  AST_DIV12_SPACING: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    (tick && clk_src_in == counter_array_pkg::SRC_DIV12) |=>
      !(tick && clk_src_in == counter_array_pkg::SRC_DIV12) [*8])
    else $error("div12 ticks too close");
  AST_ECI_ONE_TICK: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    (run_in && clk_src_in == counter_array_pkg::SRC_EXT_CNT && eci_rise) |-> tick ##1 !tick)
    else $error("external count edge not counted exactly once");
  AST_WDOG_LOCK: assert property (@(posedge clk_sys_in) disable iff (rst_in || por_in)
    wdog_locked_r |=> !wdog_en_r)
    else $error("watchdog re-enabled after permanent disable");
  AST_WDOG_MASK: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    (wdog_expire && !wdog_rst_mask_in) |=> wdog_rst_r && sys_rst_req_out)
    else $error("watchdog expiry did not request reset");
  AST_WDOG_MASKED: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    $past(wdog_rst_mask_in) |-> !wdog_rst_r)
    else $error("masked watchdog requested reset");
  AST_OVF_FLAG: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    (tick && count_r == 16'hFFFF) |=> ovf_r && count_r == 16'h0000)
    else $error("overflow flag not set on wrap");
  AST_FLAG_SET_WINS: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    (match != 6'h00) |=> (flag_r & $past(match)) == $past(match))
    else $error("flag lost when set met clear");
  AST_WDOG_RESET_ON: assert property (@(posedge clk_sys_in)
    $fell(rst_in) && !wdog_disable_in |-> wdog_en_r || wdog_locked_r)
    else $error("watchdog not enabled after reset");
  COV_OVERFLOW: cover property (@(posedge clk_sys_in) disable iff (rst_in) ovf_r);
  COV_WDOG_RST: cover property (@(posedge clk_sys_in) disable iff (rst_in) wdog_rst_r);
  COV_ECI: cover property (@(posedge clk_sys_in) disable iff (rst_in) eci_rise && tick);
  COV_IRQ: cover property (@(posedge clk_sys_in) disable iff (rst_in) irq_out);
endmodule // counter_array
`default_nettype wire

// >>> testbench/tb_counter_array.sv
/*
  self-checking bench for the counter array: clock sources, module modes, watchdog.
  assumes the assertions live in the design files and inputs are plain ports.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_counter_array;
  logic clk_sys_in = 1'b0;
  logic rst_in, por_in, run_in, timer0_ovf_in, xosc_in, external_count_input_in;
  logic [2:0] clk_src_in;
  logic [17:0] mode_in, pwm_width_in;
  logic [11:0] edge_sel_in;
  logic [95:0] compare_in, capture_out;
  logic [5:0] mod_pin_in, flag_clr_in, flag_ie_in, mod_pin_out, flag_out;
  logic ovf_clr_in, ovf_ie_in, wdog_disable_in, wdog_kick_in, wdog_limit_we_in;
  logic wdog_rst_mask_in, flash_err_in;
  logic [7:0] wdog_limit_in;
  logic [15:0] count_out, c0, c1;
  logic ovf_flag_out, irq_out, wdog_en_out, wdog_rst_out, sys_rst_req_out, prev;
  int n_fail = 0;
  int num_checks = 0;
  int hits, win, kk;
  logic [2:0] srcs [7] = '{counter_array_pkg::SRC_SYSCLK, counter_array_pkg::SRC_DIV4,
    counter_array_pkg::SRC_DIV12, 3'h6, counter_array_pkg::SRC_T0_OVF,
    counter_array_pkg::SRC_EXT_CNT, counter_array_pkg::SRC_XOSC_DIV8};
  int lens [7] = '{16, 32, 48, 16, 32, 32, 72};
  int exps [7] = '{16, 8, 4, 0, 5, 5, 4};

  // 40 MHz system clock
  always #12.5 clk_sys_in = ~clk_sys_in;

  counter_array counter_array_i (.clk_sys_in(clk_sys_in), .rst_in(rst_in), .por_in(por_in),
    .run_in(run_in), .clk_src_in(clk_src_in), .timer0_ovf_in(timer0_ovf_in),
    .xosc_in(xosc_in), .external_count_input_in(external_count_input_in),
    .mode_in(mode_in), .edge_sel_in(edge_sel_in), .pwm_width_in(pwm_width_in),
    .compare_in(compare_in), .mod_pin_in(mod_pin_in), .flag_clr_in(flag_clr_in),
    .flag_ie_in(flag_ie_in), .ovf_clr_in(ovf_clr_in), .ovf_ie_in(ovf_ie_in),
    .wdog_disable_in(wdog_disable_in), .wdog_kick_in(wdog_kick_in),
    .wdog_limit_in(wdog_limit_in), .wdog_limit_we_in(wdog_limit_we_in),
    .wdog_rst_mask_in(wdog_rst_mask_in), .flash_err_in(flash_err_in),
    .count_out(count_out), .capture_out(capture_out), .mod_pin_out(mod_pin_out),
    .flag_out(flag_out), .ovf_flag_out(ovf_flag_out), .irq_out(irq_out),
    .wdog_en_out(wdog_en_out), .wdog_rst_out(wdog_rst_out),
    .sys_rst_req_out(sys_rst_req_out));

  // wait a number of rising edges
  task automatic cycles(input int n);
    repeat (n) @(posedge clk_sys_in);
  endtask

  // compare one value and count it
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // verdict and end of run
  task automatic conclude;
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // hang guard
  initial
  begin
    #(25 * 80000);
    n_fail++;
    conclude();
  end

  // main sequence
  initial
  begin
    {rst_in, por_in, run_in} = 3'h7;
    {timer0_ovf_in, xosc_in, external_count_input_in, ovf_clr_in, ovf_ie_in} = 5'h00;
    clk_src_in = counter_array_pkg::SRC_SYSCLK;
    {mode_in, pwm_width_in, edge_sel_in, compare_in} = '0;
    {mod_pin_in, flag_clr_in, flag_ie_in} = '0;
    {wdog_disable_in, wdog_kick_in, wdog_limit_we_in, wdog_rst_mask_in, flash_err_in} = '0;
    wdog_limit_in = 8'hFF;
    cycles(16);
    rst_in <= 1'b0;
    por_in <= 1'b0;
    @(negedge clk_sys_in);
    chk(16'(wdog_en_out), 16'h0001);
    // counting rate of every clock source over a whole window
    for (int i = 0; i < 7; i++)
    begin
      @(posedge clk_sys_in);
      clk_src_in <= srcs[i];
      cycles(8);
      @(negedge clk_sys_in);
      c0 = count_out;
      for (int k = 0; k < lens[i]; k++)
      begin
        @(posedge clk_sys_in);
        timer0_ovf_in <= (srcs[i] == counter_array_pkg::SRC_T0_OVF) && k < 10 && k % 2 == 0;
        external_count_input_in <= (srcs[i] == counter_array_pkg::SRC_EXT_CNT) && k < 20
          && k % 4 < 2;
        xosc_in <= (srcs[i] == counter_array_pkg::SRC_XOSC_DIV8) && k < 64 && k % 2 == 1;
      end
      @(negedge clk_sys_in);
      c1 = count_out;
      chk(c1 - c0, 16'(exps[i]));
    end
    // rising-edge capture on module 0 with frozen counter
    @(posedge clk_sys_in);
    clk_src_in <= 3'h6;
    mode_in[2:0] <= counter_array_pkg::MODE_CAPTURE;
    edge_sel_in[1:0] <= 2'h3;
    flag_ie_in <= 6'h01;
    cycles(3);
    mod_pin_in[0] <= 1'b1;
    cycles(4);
    @(negedge clk_sys_in);
    c0 = count_out;
    chk(capture_out[15:0], c0);
    chk(16'(flag_out[0]), 16'h0001);
    chk(16'(irq_out), 16'h0001);
    // falling-edge capture meets a clear in the same cycle: the set wins
    @(posedge clk_sys_in);
    flag_clr_in <= 6'h01;
    mod_pin_in[0] <= 1'b0;
    @(posedge clk_sys_in);
    flag_clr_in <= 6'h00;
    @(negedge clk_sys_in);
    chk(16'(flag_out[0]), 16'h0001);
    @(posedge clk_sys_in);
    flag_clr_in <= 6'h01;
    @(posedge clk_sys_in);
    flag_clr_in <= 6'h00;
    cycles(3);
    @(negedge clk_sys_in);
    chk(16'(flag_out[0]), 16'h0000);
    chk(16'(irq_out), 16'h0000);
    // high-speed output on module 1, software timer on module 3
    @(posedge clk_sys_in);
    compare_in[31:16] <= c0 + 16'h0003;
    compare_in[63:48] <= c0 + 16'h0003;
    mode_in[5:3] <= counter_array_pkg::MODE_HS_OUT;
    mode_in[11:9] <= counter_array_pkg::MODE_SW_TIMER;
    cycles(2);
    clk_src_in <= counter_array_pkg::SRC_SYSCLK;
    cycles(8);
    clk_src_in <= 3'h6;
    cycles(3);
    @(negedge clk_sys_in);
    chk(16'(mod_pin_out[1]), 16'h0001);
    chk(16'({flag_out[3], flag_out[1]}), 16'h0003);
    // frequency output on module 4 toggles every four ticks
    @(posedge clk_sys_in);
    compare_in[79:64] <= 16'h0003;
    mode_in[14:12] <= counter_array_pkg::MODE_FREQ_OUT;
    clk_src_in <= counter_array_pkg::SRC_SYSCLK;
    cycles(8);
    @(negedge clk_sys_in);
    prev = mod_pin_out[4];
    hits = 0;
    repeat (64)
    begin
      @(negedge clk_sys_in);
      if (mod_pin_out[4] !== prev)
        hits++;
      prev = mod_pin_out[4];
    end
    chk(16'(hits), 16'h0010);
    // pwm duty on module 2 for every width code
    for (int w = 0; w < 5; w++)
    begin
      @(posedge clk_sys_in);
      pwm_width_in[8:6] <= 3'(w);
      compare_in[47:32] <= (w == 4) ? 16'h0000 : 16'h0003;
      mode_in[8:6] <= counter_array_pkg::MODE_PWM;
      cycles(4);
      hits = 0;
      win = (w == 4) ? 256 : (256 << w);
      repeat (win)
      begin
        @(negedge clk_sys_in);
        if (mod_pin_out[2] === 1'b1)
          hits++;
      end
      chk(16'(hits), 16'(win - ((w == 4) ? 0 : 3)));
    end
    chk(16'(flag_out[2]), 16'h0001);
    // watchdog expiry one high-byte step after a kick
    @(posedge clk_sys_in);
    wdog_limit_in <= 8'h01;
    {wdog_limit_we_in, wdog_kick_in} <= 2'h3;
    @(posedge clk_sys_in);
    {wdog_limit_we_in, wdog_kick_in} <= 2'h0;
    hits = 0;
    kk = 0;
    for (int k = 0; k < 600 && hits == 0; k++)
    begin
      @(negedge clk_sys_in);
      kk = k;
      if (wdog_rst_out === 1'b1)
        hits = 1;
    end
    chk(16'({hits[0], sys_rst_req_out, kk >= 250}), 16'h0007);
    @(negedge clk_sys_in);
    chk(16'(wdog_rst_out), 16'h0000);
    // masked watchdog raises no reset, flash error still does
    @(posedge clk_sys_in);
    {wdog_rst_mask_in, wdog_kick_in} <= 2'h3;
    @(posedge clk_sys_in);
    wdog_kick_in <= 1'b0;
    hits = 0;
    repeat (600)
    begin
      @(negedge clk_sys_in);
      if (sys_rst_req_out !== 1'b0)
        hits++;
    end
    chk(16'(hits), 16'h0000);
    @(posedge clk_sys_in);
    flash_err_in <= 1'b1;
    @(negedge clk_sys_in);
    chk(16'(sys_rst_req_out), 16'h0001);
    @(posedge clk_sys_in);
    flash_err_in <= 1'b0;
    wdog_disable_in <= 1'b1;
    // disable lock survives system reset, power-on reset frees it
    @(posedge clk_sys_in);
    wdog_disable_in <= 1'b0;
    @(negedge clk_sys_in);
    chk(16'(wdog_en_out), 16'h0000);
    @(posedge clk_sys_in);
    rst_in <= 1'b1;
    cycles(2);
    rst_in <= 1'b0;
    @(negedge clk_sys_in);
    chk(16'(wdog_en_out), 16'h0000);
    chk(count_out, 16'h0000);
    @(posedge clk_sys_in);
    {por_in, rst_in} <= 2'h3;
    @(negedge clk_sys_in);
    chk(16'(sys_rst_req_out), 16'h0001);
    cycles(2);
    {por_in, rst_in} <= 2'h0;
    @(negedge clk_sys_in);
    chk(16'(wdog_en_out), 16'h0001);
    // free run to the wrap: overflow flag, its interrupt, reset-default watchdog expiry
    @(posedge clk_sys_in);
    {wdog_rst_mask_in, ovf_ie_in} <= 2'h1;
    cycles(65535);
    @(negedge clk_sys_in);
    chk(count_out, 16'h0000);
    chk(16'({ovf_flag_out, irq_out, wdog_rst_out}), 16'h0007);
    conclude();
  end
endmodule // tb_counter_array
`default_nettype wire
